// ==== logic/ups_power_cycling_fsm.sv ====
// Power cycling state machine with its register slave on the serial bus
`timescale 1ns/100ps
module ups_power_cycling_fsm
  import ups_power_pkg::*;
#(
  parameter logic [31:0] CYCLES_PER_SECOND = SECOND_CYCLES,
  parameter logic        HAS_EXT_INPUT     = 1'b1
)(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire cable_t     cable,
  input  wire logic       button,
  input  wire logic       low_battery,
  input  wire logic       host_reboot,
  input  wire sched_t     shutdown_src,
  input  wire sched_t     wake_src,
  input  wire logic [3:0] restart_cause,
  input  wire logic       bat_run_wr,
  input  wire logic [7:0] bat_run_data,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            system_power_en,
  output logic            status_slow_blink,
  output logic            beep,
  output logic            retention,
  output logic            rtc_run
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pwr_state_t  state;
  pwr_state_t  next_state;
  i2c_state_t  i2c_state;
  cable_t      cable_now;
  cable_t      cable_seen;
  logic        cable_any;
  logic        button_q;
  logic        button_press;
  logic        sec_tick;
  logic        bat_expired;
  logic        shut_expired;
  logic        poll_tick;
  logic [7:0]  battery_run_limit;
  logic [7:0]  mode_reg;
  logic [15:0] info;
  logic        info_clear;
  logic        boot_seen;
  logic        shut_set;
  logic [3:0]  shut_code;
  logic        wake_set;
  logic [3:0]  wake_code;
  logic        scl_q;
  logic        sda_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic        rw;
  logic        ptr_loaded;
  logic [7:0]  ptr;
  logic        lo_zero;
  logic        nack;
  logic [7:0]  rd_byte;

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  // External input is ignored on variants without it
  assign cable_now.usb_ok = cable.usb_ok;
  assign cable_now.ext_ok = cable.ext_ok & HAS_EXT_INPUT;
  assign cable_any        = cable_now.usb_ok | cable_now.ext_ok;
  assign button_press     = button & ~button_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      button_q <= 1'b0;
    end else begin
      button_q <= button;
    end
  end

  // ****************************************************************
  // Timebase and interval timers
  // ****************************************************************
  sec_timer #(.WIDTH(32)) u_second (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (1'b1),
    .tick  (1'b1),
    .limit (CYCLES_PER_SECOND),
    .done  (sec_tick)
  );

  // Count clears on leaving battery state
  sec_timer #(.WIDTH(8)) u_battery (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (state == ST_BATTERY),
    .tick  (sec_tick),
    .limit (battery_run_limit),
    .done  (bat_expired)
  );

  sec_timer #(.WIDTH(8)) u_shutdown (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (state == ST_SHUTDOWN),
    .tick  (sec_tick),
    .limit (SHUTDOWN_S),
    .done  (shut_expired)
  );

  sec_timer #(.WIDTH(8)) u_poll (
    .clk   (clk),
    .rst_b (rst_b),
    .run   (state == ST_RETENTION),
    .tick  (sec_tick),
    .limit (POLL_S),
    .done  (poll_tick)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      battery_run_limit <= BAT_RUN_S;
    end else if (bat_run_wr) begin
      battery_run_limit <= bat_run_data;
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    shut_set   = 1'b0;
    shut_code  = 4'h0;
    wake_set   = 1'b0;
    wake_code  = 4'h0;
    unique case (state)
      ST_CABLE, ST_BATTERY: begin
        if (button_press) begin
          next_state = ST_SHUTDOWN;
          shut_set   = 1'b1;
          shut_code  = SHUT_BUTTON;
        end else if (state == ST_BATTERY && low_battery) begin
          next_state = ST_SHUTDOWN;
          shut_set   = 1'b1;
          shut_code  = SHUT_LOW_BAT;
        end else if (|shutdown_src) begin
          next_state = ST_SHUTDOWN;
          shut_set   = 1'b1;
          if (shutdown_src.simple_sched) begin
            shut_code = SHUT_SIMPLE;
          end else if (shutdown_src.ext_sched) begin
            shut_code = SHUT_EXTENDED;
          end else begin
            shut_code = SHUT_EVENT;
          end
        end else if (state == ST_CABLE && !cable_any) begin
          next_state = ST_BATTERY;
        end else if (state == ST_BATTERY && cable_any) begin
          next_state = ST_CABLE;
        end else if (state == ST_BATTERY && bat_expired) begin
          next_state = ST_SHUTDOWN;
          shut_set   = 1'b1;
          shut_code  = SHUT_TIMED;
        end else if (host_reboot) begin
          wake_set  = 1'b1;
          wake_code = WAKE_REBOOT;
        end
      end
      ST_SHUTDOWN: begin
        if (shut_expired) begin
          next_state = ST_RETENTION;
        end
      end
      ST_RETENTION: begin
        if (button_press) begin
          // Immediate, does not wait for the next cable poll
          next_state = cable_any ? ST_CABLE : ST_BATTERY;
          wake_set   = 1'b1;
          wake_code  = WAKE_BUTTON;
        end else if (|wake_src) begin
          next_state = cable_any ? ST_CABLE : ST_BATTERY;
          wake_set   = 1'b1;
          if (wake_src.simple_sched) begin
            wake_code = WAKE_SIMPLE;
          end else if (wake_src.ext_sched) begin
            wake_code = WAKE_EXTENDED;
          end else begin
            wake_code = WAKE_EVENT;
          end
        end else if (poll_tick && cable_any && cable_now != cable_seen) begin
          next_state = ST_CABLE;
          wake_set   = 1'b1;
          if (cable_now.usb_ok && !cable_seen.usb_ok) begin
            wake_code = WAKE_HOST_V;
          end else begin
            wake_code = WAKE_EXT_V;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_CABLE;
    end else begin
      state <= next_state;
    end
  end

  // Cable picture at retention entry and at each poll, so that a
  // connection present at shutdown does not wake at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cable_seen <= '0;
    end else if (next_state == ST_RETENTION && state != ST_RETENTION) begin
      cable_seen <= cable_now;
    end else if (state == ST_RETENTION && poll_tick) begin
      cable_seen <= cable_now;
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      system_power_en   <= 1'b1;
      retention         <= 1'b0;
      status_slow_blink <= 1'b0;
      beep              <= 1'b0;
      rtc_run           <= 1'b1;
    end else begin
      system_power_en   <= next_state != ST_RETENTION;
      retention         <= next_state == ST_RETENTION;
      status_slow_blink <= next_state == ST_BATTERY;
      beep <= state == ST_CABLE && next_state == ST_BATTERY;
      rtc_run           <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg <= MODE_CABLE;
    end else if (cable_any && next_state != ST_RETENTION) begin
      mode_reg <= MODE_CABLE;
    end else begin
      mode_reg <= MODE_BATTERY;
    end
  end

  // ****************************************************************
  // Reason register
  // ****************************************************************
  // Hardware updates win over a clear landing in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      info      <= INFO_RESET;
      boot_seen <= 1'b0;
    end else begin
      boot_seen <= 1'b1;
      if (info_clear) begin
        info <= INFO_RESET;
      end
      if (shut_set) begin
        info[SHUT_LSB +: 4] <= shut_code;
      end
      if (wake_set) begin
        info[WAKE_LSB +: 4] <= wake_code;
      end
      if (!boot_seen) begin
        info[RESTART_LSB +: 4] <= restart_cause;
      end
    end
  end

  // ****************************************************************
  // Serial bus slave
  // ****************************************************************
  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda_in;
  assign bus_stop  = scl & scl_q & ~sda_q & sda_in;
  assign sda_out   = 1'b0;

  always_comb begin
    if (ptr == MODE_OFFSET) begin
      rd_byte = mode_reg;
    end else if (ptr == INFO_OFFSET) begin
      rd_byte = info[7:0];
    end else if (ptr == INFO_HI_OFFSET) begin
      rd_byte = {4'h0, info[11:8]};
    end else begin
      rd_byte = BYTE_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Word data arrive low byte first; only all-zero words clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      i2c_state  <= I_IDLE;
      bit_cnt    <= 4'h0;
      rx         <= BYTE_ZERO;
      tx         <= BYTE_ZERO;
      rw         <= 1'b0;
      ptr_loaded <= 1'b0;
      ptr        <= BYTE_ZERO;
      lo_zero    <= 1'b0;
      nack       <= 1'b0;
      sda_oe     <= 1'b0;
      info_clear <= 1'b0;
    end else begin
      info_clear <= 1'b0;
      if (bus_start) begin
        i2c_state  <= I_ADDR;
        bit_cnt    <= 4'h0;
        ptr_loaded <= 1'b0;
        lo_zero    <= 1'b0;
        sda_oe     <= 1'b0;
      end else if (bus_stop) begin
        i2c_state <= I_IDLE;
        sda_oe    <= 1'b0;
      end else begin
        unique case (i2c_state)
          I_IDLE: begin
            sda_oe <= 1'b0;
          end
          I_ADDR, I_WRITE: begin
            if (scl_rise) begin
              rx      <= {rx[6:0], sda_in};
              bit_cnt <= bit_cnt + 1'b1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (i2c_state == I_ADDR) begin
                if (rx[7:1] == SLAVE_ADDR) begin
                  rw        <= rx[0];
                  sda_oe    <= 1'b1;
                  i2c_state <= I_ACK_ADDR;
                end else begin
                  i2c_state <= I_IDLE;
                end
              end else begin
                sda_oe    <= 1'b1;
                i2c_state <= I_ACK_WR;
                if (!ptr_loaded) begin
                  ptr        <= rx;
                  ptr_loaded <= 1'b1;
                end else begin
                  ptr <= ptr + 1'b1;
                  if (ptr == INFO_OFFSET) begin
                    lo_zero <= rx == BYTE_ZERO;
                  end else if (ptr == INFO_HI_OFFSET) begin
                    info_clear <= lo_zero && rx == BYTE_ZERO;
                    lo_zero    <= 1'b0;
                  end
                end
              end
            end
          end
          I_ACK_ADDR: begin
            if (scl_fall) begin
              if (rw) begin
                sda_oe    <= ~rd_byte[7];
                tx        <= {rd_byte[6:0], 1'b1};
                bit_cnt   <= 4'h1;
                i2c_state <= I_READ;
              end else begin
                sda_oe    <= 1'b0;
                i2c_state <= I_WRITE;
              end
            end
          end
          I_ACK_WR: begin
            if (scl_fall) begin
              sda_oe    <= 1'b0;
              i2c_state <= I_WRITE;
            end
          end
          I_READ: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe    <= 1'b0;
                ptr       <= ptr + 1'b1;
                i2c_state <= I_ACK_RD;
              end else begin
                sda_oe  <= ~tx[7];
                tx      <= {tx[6:0], 1'b1};
                bit_cnt <= bit_cnt + 1'b1;
              end
            end
          end
          I_ACK_RD: begin
            if (scl_rise) begin
              nack <= sda_in;
            end else if (scl_fall) begin
              if (nack) begin
                i2c_state <= I_IDLE;
              end else begin
                sda_oe    <= ~rd_byte[7];
                tx        <= {rd_byte[6:0], 1'b1};
                bit_cnt   <= 4'h1;
                i2c_state <= I_READ;
              end
            end
          end
          default: begin
            i2c_state <= I_IDLE;
          end
        endcase
      end
    end
  end

endmodule // ups_power_cycling_fsm

// ==== logic/ups_power_pkg.sv ====
// Shared constants, types and field layout of the power cycling controller
// Behaviour
// - Powering mode byte readable at 0x69, 0x00
// - Mode reads 0x01 on cable, 0x02 battery
// - Cable loss: seamless battery switch, beep, blink
// - Battery time expiry starts safe shutdown, retention
// - Button starts safe shutdown, then retention
// - Real-time clock keeps running in retention
// - Wake on button, cable, or scheduler event
// - Poll cable every 10 s in retention
// - Button wakes retention at once, battery powered; code wakes in cable mode if a cable is present
// - Retention entry cuts power despite external cable
// - External input loss acts like host loss
// - 16-bit reason register at 0x69, 0x28
// - Bits 3:0 hold last shutdown cause
// - Bits 7:4 hold last wake cause
// - Bits 11:8 hold controller restart cause
// - Writing word 0x0000 clears all reasons
package ups_power_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [6:0]  SLAVE_ADDR     = 7'h69;
  localparam logic [7:0]  MODE_OFFSET    = 8'h00;
  localparam logic [7:0]  INFO_OFFSET    = 8'h28;
  localparam logic [7:0]  INFO_HI_OFFSET = 8'h29;
  localparam logic [7:0]  MODE_CABLE     = 8'h01;
  localparam logic [7:0]  MODE_BATTERY   = 8'h02;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [15:0] INFO_RESET     = 16'h0000;
  localparam int          SHUT_LSB       = 0;
  localparam int          WAKE_LSB       = 4;
  localparam int          RESTART_LSB    = 8;

  // ****************************************************************
  // Reason codes
  // ****************************************************************
  localparam logic [3:0] SHUT_BUTTON    = 4'h1;
  localparam logic [3:0] SHUT_LOW_BAT   = 4'h2;
  localparam logic [3:0] SHUT_TIMED     = 4'h3;
  localparam logic [3:0] SHUT_SIMPLE    = 4'h4;
  localparam logic [3:0] SHUT_EXTENDED  = 4'h5;
  localparam logic [3:0] SHUT_EVENT     = 4'h6;
  localparam logic [3:0] WAKE_BUTTON    = 4'h1;
  localparam logic [3:0] WAKE_HOST_V    = 4'h2;
  localparam logic [3:0] WAKE_REBOOT    = 4'h3;
  localparam logic [3:0] WAKE_EXT_V     = 4'h4;
  localparam logic [3:0] WAKE_SIMPLE    = 4'h5;
  localparam logic [3:0] WAKE_EXTENDED  = 4'h6;
  localparam logic [3:0] WAKE_EVENT     = 4'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint unsigned CLOCK_HZ = 40_000_000;
  localparam longint unsigned SECOND_S = 1;
  localparam logic [31:0] SECOND_CYCLES = 32'(CLOCK_HZ * SECOND_S);
  localparam logic [7:0]  BAT_RUN_S     = 8'h46;
  localparam logic [7:0]  POLL_S        = 8'h0a;
  localparam logic [7:0]  SHUTDOWN_S    = 8'h14;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_CABLE     = 2'b00,
    ST_BATTERY   = 2'b01,
    ST_SHUTDOWN  = 2'b11,
    ST_RETENTION = 2'b10
  } pwr_state_t;

  typedef enum logic [2:0] {
    I_IDLE     = 3'b000,
    I_ADDR     = 3'b001,
    I_ACK_ADDR = 3'b011,
    I_WRITE    = 3'b010,
    I_ACK_WR   = 3'b110,
    I_READ     = 3'b111,
    I_ACK_RD   = 3'b101
  } i2c_state_t;

  typedef struct packed {
    logic usb_ok;
    logic ext_ok;
  } cable_t;

  typedef struct packed {
    logic simple_sched;
    logic ext_sched;
    logic event_hit;
  } sched_t;

endpackage

// ==== logic/sec_timer.sv ====
// Periodic tick counter with a one-cycle done pulse
`timescale 1ns/100ps
module sec_timer #(
  parameter int WIDTH = 8
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  done
);

  logic [WIDTH-1:0] count;

  // Dropping run restarts the count from zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!run) begin
        count <= '0;
      end else if (tick) begin
        if (count == WIDTH'(limit - 1'b1)) begin
          count <= '0;
          done  <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule // sec_timer

// ==== testbench/host_i2c_model.sv ====
// Host side serial bus master that reads and clears controller registers
`timescale 1ns/100ps
module host_i2c_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drive
);
  logic acked;

  initial begin
    scl = 1'b1;
    sda_drive = 1'b1;
    acked = 1'b1;
  end

  // ********************
  // Bus conditions
  // ********************
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // Works from idle and as a repeated start with the clock low
  task automatic start_cond();
    @(posedge clk);
    sda_drive <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_drive <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask

  task automatic stop_cond();
    sda_drive <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drive <= 1'b1;
    half();
  endtask

  // Data only moves while the clock is low, never beside a clock edge
  task automatic bit_x(input logic b, output logic r);
    sda_drive <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    half();
  endtask

  // Kind 0: expect slave ack, 1: master acks, 2: master ends the read
  task automatic byte_x(input logic [7:0] d, input logic [1:0] kind,
                        output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(kind != 2'd1, r);
    if (kind == 2'd0 && r !== 1'b0) begin
      acked = 1'b0;
    end
  endtask

  // ********************
  // Register access
  // ********************
  task automatic reg_write(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [15:0] data);
    logic [7:0] q;
    acked = 1'b1;
    start_cond();
    byte_x({dev, 1'b0}, 2'd0, q);
    byte_x(ptr, 2'd0, q);
    byte_x(data[7:0], 2'd0, q);
    byte_x(data[15:8], 2'd0, q);
    stop_cond();
  endtask

  task automatic reg_read(input logic [6:0] dev, input logic [7:0] ptr,
                          input logic word, output logic [15:0] v);
    logic [7:0] q;
    acked = 1'b1;
    v = 16'h0000;
    start_cond();
    byte_x({dev, 1'b0}, 2'd0, q);
    byte_x(ptr, 2'd0, q);
    start_cond();
    byte_x({dev, 1'b1}, 2'd0, q);
    byte_x(8'hff, word ? 2'd1 : 2'd2, q);
    v[7:0] = q;
    if (word) begin
      byte_x(8'hff, 2'd2, q);
      v[15:8] = q;
    end
    stop_cond();
  endtask
endmodule // host_i2c_model

// ==== testbench/ups_power_cycling_assertions.sv ====
// Port level checks of the power cycling controller
`timescale 1ns/100ps
module ups_power_cycling_assertions
  import ups_power_pkg::*;
#(
  parameter logic [31:0] CYCLES_PER_SECOND = SECOND_CYCLES
)(
  input wire logic   clk,
  input wire logic   rst_b,
  input wire cable_t cable,
  input wire logic   button,
  input wire sched_t wake_src,
  input wire logic   system_power_en,
  input wire logic   status_slow_blink,
  input wire logic   beep,
  input wire logic   retention,
  input wire logic   rtc_run
);
  // First second may be partial, hence the slack
  localparam int SEC     = int'(CYCLES_PER_SECOND);
  localparam int SD_LO   = 19 * SEC - 12;
  localparam int SD_HI   = 20 * SEC + 4;
  localparam int POLL_HI = 11 * SEC + 3;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_beep_cause: assert property (beep |-> $past(cable) == 2'b00)
    else $error("beep without cable loss");
  a_beep_blink: assert property (beep |-> $rose(status_slow_blink))
    else $error("beep without slow blink start");
  a_beep_single: assert property (beep |=> !beep)
    else $error("beep longer than one cycle");
  a_rtc_alive: assert property (rtc_run)
    else $error("real time clock stopped");
  a_power_cut: assert property (system_power_en == !retention)
    else $error("system power not tied to retention");
  a_cable_back: assert property (status_slow_blink && cable != 2'b00
    |=> !status_slow_blink) else $error("battery kept with cable");
  a_button_wake: assert property (retention && $rose(button)
    |-> ##[1:2] !retention) else $error("button did not wake");
  a_event_wake: assert property (retention && wake_src != '0
    |-> ##[1:2] !retention) else $error("wake source ignored");
  a_poll_wake: assert property (retention && cable != 2'b00
    && $past(cable) == 2'b00 |-> ##[1:POLL_HI] !retention)
    else $error("cable not seen within poll time");
  a_press_shut: assert property (!retention && $rose(button)
    |=> !retention [*8] ##[SD_LO:SD_HI] retention)
    else $error("shutdown time after press wrong");
endmodule // ups_power_cycling_assertions

// ==== testbench/testbench.sv ====
// Self-checking bench of the power cycling controller
`timescale 1ns/100ps
module testbench
  import ups_power_pkg::*;
;
  localparam int SEC = 20;
  logic        clk, rst_b, button, low_battery, host_reboot, bat_run_wr;
  cable_t      cable;
  sched_t      shutdown_src, wake_src;
  logic [3:0]  restart_cause, es, ew;
  logic [7:0]  bat_run_data;
  logic [15:0] v;
  wire logic   scl, sda_drive, sda_out, sda_oe, sda_line;
  wire logic   system_power_en, status_slow_blink, beep, retention, rtc_run;
  int          mismatches, checked;
  logic [3:0]  codes [7] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h7, 4'he, 4'hf};

  // Open drain line with pull-up
  assign sda_line = sda_drive & ~(sda_oe & ~sda_out);
  always #12.5 clk = ~clk;

  ups_power_cycling_fsm #(.CYCLES_PER_SECOND(32'h14), .HAS_EXT_INPUT(1'b1))
    i_dut (.clk(clk), .rst_b(rst_b), .cable(cable), .button(button),
           .low_battery(low_battery), .host_reboot(host_reboot),
           .shutdown_src(shutdown_src), .wake_src(wake_src),
           .restart_cause(restart_cause), .bat_run_wr(bat_run_wr),
           .bat_run_data(bat_run_data), .scl(scl), .sda_in(sda_line),
           .sda_out(sda_out), .sda_oe(sda_oe),
           .system_power_en(system_power_en),
           .status_slow_blink(status_slow_blink), .beep(beep),
           .retention(retention), .rtc_run(rtc_run));
  host_i2c_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl),
                         .sda_drive(sda_drive));

  // ********************
  // Helpers
  // ********************
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] ptr, input logic word,
                        input logic [15:0] mask, input logic [15:0] exp);
    i_host.reg_read(SLAVE_ADDR, ptr, word, v);
    chk(v & mask, exp);
  endtask

  // Waits for the retention level, also checking it did not come early
  task automatic wait_ret(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (retention !== lvl) begin
      @(negedge clk);
      n++;
      if (n > hi) begin
        mismatches++;
        $display("mismatch at %0t: got %h expected %h", $time, retention,
                 lvl);
        report_and_stop();
      end
    end
    chk(16'(n >= lo), 16'h0001);
  endtask

  task automatic do_reset(input logic [3:0] code);
    @(posedge clk);
    rst_b <= 1'b0;
    restart_cause <= code;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bat_run_wr <= 1'b1;
    @(posedge clk);
    bat_run_wr <= 1'b0;
  endtask

  task automatic press();
    @(posedge clk);
    button <= 1'b1;
    repeat (3) @(posedge clk);
    button <= 1'b0;
  endtask

  // ********************
  // Sequence
  // ********************
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {button, low_battery, host_reboot, bat_run_wr} = 4'h0;
    cable = cable_t'(2'b10);
    shutdown_src = '0;
    wake_src = '0;
    restart_cause = 4'h0;
    bat_run_data = BAT_RUN_S;
    mismatches = 0;
    checked = 0;
    foreach (codes[i]) begin
      do_reset(codes[i]);
      rd_chk(INFO_OFFSET, 1'b1, 16'hffff, {4'h0, codes[i], 8'h00});
    end
    rd_chk(MODE_OFFSET, 1'b0, 16'h00ff, {8'h00, MODE_CABLE});
    i_host.reg_write(SLAVE_ADDR, INFO_OFFSET, 16'hf0ff);
    rd_chk(INFO_OFFSET, 1'b1, 16'hffff, 16'h0f00);
    i_host.reg_read(7'h6a, MODE_OFFSET, 1'b0, v);
    chk({15'h0, i_host.acked}, 16'h0000);
    rd_chk(8'h10, 1'b0, 16'hffff, 16'h0000);
    i_host.reg_write(SLAVE_ADDR, INFO_OFFSET, 16'h0000);
    rd_chk(INFO_OFFSET, 1'b1, 16'hffff, INFO_RESET);
    @(posedge clk);
    host_reboot <= 1'b1;
    @(posedge clk);
    host_reboot <= 1'b0;
    rd_chk(INFO_OFFSET, 1'b1, 16'hffff, {8'h00, WAKE_REBOOT, 4'h0});
    @(posedge clk);
    cable <= '0;
    repeat (2) @(negedge clk);
    chk({14'h0, beep, status_slow_blink}, 16'h0003);
    rd_chk(MODE_OFFSET, 1'b0, 16'h00ff, {8'h00, MODE_BATTERY});
    repeat (600) @(posedge clk);
    cable <= cable_t'(2'b10);
    repeat (5) @(posedge clk);
    cable <= '0;
    wait_ret(1'b1, 88 * SEC, 91 * SEC);
    chk({14'h0, system_power_en, rtc_run}, 16'h0001);
    rd_chk(INFO_OFFSET, 1'b1, 16'h000f, {12'h0, SHUT_TIMED});
    press();
    wait_ret(1'b0, 0, 3);
    rd_chk(MODE_OFFSET, 1'b0, 16'h00ff, {8'h00, MODE_BATTERY});
    rd_chk(INFO_OFFSET, 1'b1, 16'h00f0, {8'h00, WAKE_BUTTON, 4'h0});
    @(posedge clk);
    low_battery <= 1'b1;
    wait_ret(1'b1, 19 * SEC - 5, 21 * SEC + 5);
    @(posedge clk);
    low_battery <= 1'b0;
    rd_chk(INFO_OFFSET, 1'b1, 16'h000f, {12'h0, SHUT_LOW_BAT});
    @(posedge clk);
    cable <= cable_t'(2'b01);
    wait_ret(1'b0, 0, 11 * SEC + 5);
    rd_chk(INFO_OFFSET, 1'b1, 16'h00f0, {8'h00, WAKE_EXT_V, 4'h0});
    rd_chk(MODE_OFFSET, 1'b0, 16'h00ff, {8'h00, MODE_CABLE});
    for (int k = 0; k < 4; k++) begin
      es = (k < 3) ? SHUT_SIMPLE + 4'(k) : SHUT_BUTTON;
      ew = (k < 3) ? WAKE_SIMPLE + 4'(k) : WAKE_BUTTON;
      @(posedge clk);
      if (k < 3) begin
        shutdown_src <= sched_t'(3'b100 >> k);
      end else begin
        button <= 1'b1;
      end
      repeat (4) @(posedge clk);
      shutdown_src <= '0;
      button <= 1'b0;
      wait_ret(1'b1, 19 * SEC - 5, 21 * SEC + 5);
      chk({15'h0, system_power_en}, 16'h0000);
      @(posedge clk);
      if (k < 3) begin
        wake_src <= sched_t'(3'b100 >> k);
      end else begin
        button <= 1'b1;
      end
      wait_ret(1'b0, 0, 3);
      @(posedge clk);
      wake_src <= '0;
      button <= 1'b0;
      rd_chk(INFO_OFFSET, 1'b1, 16'h00ff, {8'h00, ew, es});
    end
    report_and_stop();
  end
endmodule // testbench

bind ups_power_cycling_fsm ups_power_cycling_assertions
  #(.CYCLES_PER_SECOND(CYCLES_PER_SECOND))
  i_chk (.clk(clk), .rst_b(rst_b), .cable(cable), .button(button),
         .wake_src(wake_src), .system_power_en(system_power_en),
         .status_slow_blink(status_slow_blink), .beep(beep),
         .retention(retention), .rtc_run(rtc_run));
